// >>> dctd_pkg.sv
/*
  Package for the duty-cycle temperature decoder host readout.
  Holds the state encoding, widths, prescaler figures and the byte
  offsets of the result bytes. Assumes a 25 MHz reference clock.
*/
package dctd_pkg;

  // Counter width and reference clock.
  localparam int unsigned CNT_W        = 16;
  localparam int unsigned REF_CLK_HZ   = 25000000;

  // Counters advance once every twelve reference cycles.
  localparam int unsigned PRESCALE_DIV = 12;
  localparam logic [3:0]  PRESCALE_MAX = 4'(PRESCALE_DIV - 1);

  // Full-scale count that marks a stuck or missing sensor output.
  localparam logic [CNT_W-1:0] CNT_FULL  = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  // Result byte locations, low byte first, high period then low period.
  localparam logic [7:0] RES_HIGH_LO_ADDR = 8'h8A;
  localparam logic [7:0] RES_LOW_LO_ADDR  = 8'h8B;
  localparam logic [7:0] RES_HIGH_HI_ADDR = 8'h8C;
  localparam logic [7:0] RES_LOW_HI_ADDR  = 8'h8D;

  // Calibration constants of the temperature formula.
  localparam int unsigned TEMP_OFFSET_C = 235;
  localparam int unsigned TEMP_SLOPE_C  = 400;

  // Measurement sequence states.
  typedef enum logic [2:0] {
    DCTD_IDLE      = 3'b000,
    DCTD_WAIT_LOW  = 3'b001,
    DCTD_WAIT_RISE = 3'b010,
    DCTD_CNT_HIGH  = 3'b011,
    DCTD_CNT_LOW   = 3'b100
  } dctd_state_e;

endpackage

// >>> dctd_decoder.sv
/*
  Host readout for a sensor whose single output is a square wave.
  Measures the high period and the low period with two 16-bit counters
  clocked at the reference rate divided by twelve, and holds both as
  low and high bytes.

  A start pulse taken while idle clears both counters and arms the sequence. The block
  then waits for the line to be low, so that a high phase already under
  way is never measured in part. The next rising edge starts the high
  count, the falling edge hands over to the low count, and the rising
  edge after that completes the measurement and latches both results.

  The results are ratiometric: the temperature follows from the ratio of
  the two counts, so the exact reference rate does not matter as long as
  it is steady over both phases.

  Assumes the sensor pin is asynchronous to ref_clk and that a start
  pulse comes from logic on ref_clk. Assumes the high phase never lasts
  long enough to fill a counter; a full counter is reported as an error
  and leaves the previous results untouched.
*/
// Contract
// - Host measures both high and low periods to derive temperature.
// - Counting clock exact rate irrelevant; must be stable and fast enough.
// - Exactly one input line from the sensor is used.
// - Counters advance at reference clock divided by twelve.
// - Counting begins only once mode and run control are both set.
// - One counter runs while output high, another while output low.
// - Clear both counters, wait for low before arming for rise.
// - Both counters are sixteen bits wide.
// - Rise starts high count; fall swaps; next rise completes.
// - Results held as low and high bytes, locations 8A to 8D.
// - Polling may lag edges up to 24 clocks; here edges lag two to three clocks.
// - Temperature equals 235 minus 400 times high over low.
`timescale 1ns/100ps

module dctd_decoder
  import dctd_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             sensor_in,
  input  wire logic             start,
  input  wire logic [7:0]       byte_addr,
  output logic      [7:0]       byte_data,
  output logic      [CNT_W-1:0] high_period,
  output logic      [CNT_W-1:0] low_period,
  output logic                  busy,
  output logic                  result_valid,
  output logic                  error_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchroniser.

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;
  logic pin_meta_reg;
  logic pin_sync_reg;
  logic pin_prev_reg;

  // Reset is asserted at once and released through two flip-flops.
  // An unsynchronised release could reach some flip-flops one edge
  // before others and leave the sequence in a state no edge led to.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // The single sensor line passes two flip-flops before use.
  // The first flop may go metastable, so only the second is read.
  // A third flop keeps the previous level for edge detection.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= sensor_in;
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic pin_rise;
  logic pin_fall;

  // Edges seen two to three cycles after the pin moves, equally on both.
  // Both edges pass the same delay, so the delay adds no error to the measured periods.
  assign pin_rise = pin_sync_reg & ~pin_prev_reg;
  assign pin_fall = ~pin_sync_reg & pin_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: one tick every twelve reference cycles.

  logic [3:0] pre_reg;
  logic [3:0] pre_next;
  logic       tick;
  logic       mode_cfg_reg;
  logic       run_ctl_reg;

  // The divider runs only while a counter may run, so the high period starts
  // on a fresh prescale phase; the low period keeps the phase left at the fall.
  // A tick that meets the ending edge is dropped, so a count may read low.
  always_comb begin
    pre_next = pre_reg;
    tick     = 1'b0;
    if (mode_cfg_reg && run_ctl_reg) begin
      if (pre_reg == PRESCALE_MAX) begin
        pre_next = 4'h0;
        tick     = 1'b1;
      end else begin
        pre_next = pre_reg + 4'h1;
      end
    end else begin
      pre_next = 4'h0;
    end
  end

  // Registers the divider phase.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 4'h0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequence and period counters.

  // Sequence state, run controls, live counters, held results and flags.
  dctd_state_e      state_reg;
  dctd_state_e      state_next;
  logic             mode_cfg_next;
  logic             run_ctl_next;
  logic [CNT_W-1:0] hi_cnt_reg;
  logic [CNT_W-1:0] hi_cnt_next;
  logic [CNT_W-1:0] lo_cnt_reg;
  logic [CNT_W-1:0] lo_cnt_next;
  logic [CNT_W-1:0] hi_res_reg;
  logic [CNT_W-1:0] hi_res_next;
  logic [CNT_W-1:0] lo_res_reg;
  logic [CNT_W-1:0] lo_res_next;
  logic             valid_reg;
  logic             valid_next;
  logic             err_reg;
  logic             err_next;

  // Next-state logic for the edge sequence, counters and results.
  // A taken start clears the counters and leaves the held results alone.
  // The high counter runs only in the high state and the low counter only
  // in the low state; a counter stuck at full scale ends with an error.
  always_comb begin
    state_next    = state_reg;
    mode_cfg_next = mode_cfg_reg;
    run_ctl_next  = run_ctl_reg;
    hi_cnt_next   = hi_cnt_reg;
    lo_cnt_next   = lo_cnt_reg;
    hi_res_next   = hi_res_reg;
    lo_res_next   = lo_res_reg;
    valid_next    = valid_reg;
    err_next      = err_reg;
    case (state_reg)
      DCTD_IDLE: begin
        if (start) begin
          hi_cnt_next   = CNT_RESET;
          lo_cnt_next   = CNT_RESET;
          mode_cfg_next = 1'b1;
          run_ctl_next  = 1'b0;
          valid_next    = 1'b0;
          err_next      = 1'b0;
          state_next    = DCTD_WAIT_LOW;
        end
      end
      DCTD_WAIT_LOW: begin
        if (!pin_sync_reg) begin
          state_next = DCTD_WAIT_RISE;
        end
      end
      DCTD_WAIT_RISE: begin
        if (pin_rise) begin
          run_ctl_next = 1'b1;
          state_next   = DCTD_CNT_HIGH;
        end
      end
      DCTD_CNT_HIGH: begin
        if (pin_fall) begin
          state_next = DCTD_CNT_LOW;
        end else if (tick) begin
          if (hi_cnt_reg == CNT_FULL) begin
            err_next      = 1'b1;
            run_ctl_next  = 1'b0;
            mode_cfg_next = 1'b0;
            state_next    = DCTD_IDLE;
          end else begin
            hi_cnt_next = hi_cnt_reg + 16'h0001;
          end
        end
      end
      DCTD_CNT_LOW: begin
        if (pin_rise) begin
          hi_res_next   = hi_cnt_reg;
          lo_res_next   = lo_cnt_reg;
          valid_next    = 1'b1;
          run_ctl_next  = 1'b0;
          mode_cfg_next = 1'b0;
          state_next    = DCTD_IDLE;
        end else if (tick) begin
          if (lo_cnt_reg == CNT_FULL) begin
            err_next      = 1'b1;
            run_ctl_next  = 1'b0;
            mode_cfg_next = 1'b0;
            state_next    = DCTD_IDLE;
          end else begin
            lo_cnt_next = lo_cnt_reg + 16'h0001;
          end
        end
      end
      default: begin
        state_next = DCTD_IDLE;
      end
    endcase
  end

  // Registers the sequence state, counters and held results.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= DCTD_IDLE;
      mode_cfg_reg <= 1'b0;
      run_ctl_reg  <= 1'b0;
      hi_cnt_reg   <= CNT_RESET;
      lo_cnt_reg   <= CNT_RESET;
      hi_res_reg   <= CNT_RESET;
      lo_res_reg   <= CNT_RESET;
      valid_reg    <= 1'b0;
      err_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      mode_cfg_reg <= mode_cfg_next;
      run_ctl_reg  <= run_ctl_next;
      hi_cnt_reg   <= hi_cnt_next;
      lo_cnt_reg   <= lo_cnt_next;
      hi_res_reg   <= hi_res_next;
      lo_res_reg   <= lo_res_next;
      valid_reg    <= valid_next;
      err_reg      <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result byte read port and registered outputs.

  logic [7:0] byte_next;

  // Byte select of the held results; unknown locations read zero.
  // The selected byte is registered with the other outputs, a cycle late.
  always_comb begin
    if (byte_addr == RES_HIGH_LO_ADDR) begin
      byte_next = hi_res_reg[7:0];
    end else if (byte_addr == RES_LOW_LO_ADDR) begin
      byte_next = lo_res_reg[7:0];
    end else if (byte_addr == RES_HIGH_HI_ADDR) begin
      byte_next = hi_res_reg[15:8];
    end else if (byte_addr == RES_LOW_HI_ADDR) begin
      byte_next = lo_res_reg[15:8];
    end else begin
      byte_next = 8'h00;
    end
  end

  // Every output comes from a flip-flop.
  // Values other than byte_data come from the next-state terms, so those outputs move with the state.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_data    <= 8'h00;
      high_period  <= CNT_RESET;
      low_period   <= CNT_RESET;
      busy         <= 1'b0;
      result_valid <= 1'b0;
      error_flag   <= 1'b0;
    end else begin
      byte_data    <= byte_next;
      high_period  <= hi_res_next;
      low_period   <= lo_res_next;
      busy         <= (state_next != DCTD_IDLE);
      result_valid <= valid_next;
      error_flag   <= err_next;
    end
  end

endmodule

// >>> dctd_sva.sv
/* Port checker for the decoder.
   Assumes binding to every dctd_decoder instance. */
`timescale 1ns/100ps
module dctd_sva
  import dctd_pkg::*;
(
  input wire logic             ref_clk,
  input wire logic             resetn,
  input wire logic             sensor_in,
  input wire logic             start,
  input wire logic [7:0]       byte_addr,
  input wire logic [7:0]       byte_data,
  input wire logic [CNT_W-1:0] high_period,
  input wire logic [CNT_W-1:0] low_period,
  input wire logic             busy,
  input wire logic             result_valid,
  input wire logic             error_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////
  // Result byte expected at one address.
  function automatic logic [7:0] sel(logic [7:0] a, logic [15:0] h, l);
    case (a)
      RES_HIGH_LO_ADDR: return h[7:0];
      RES_LOW_LO_ADDR:  return l[7:0];
      RES_HIGH_HI_ADDR: return h[15:8];
      RES_LOW_HI_ADDR:  return l[15:8];
      default: return 8'h00;
    endcase
  endfunction
  // A start that the idle block must take.
  sequence s_take;
    start && !busy && $past(resetn, 3);
  endsequence
  property p_take;
    s_take |=> busy && !result_valid && !error_flag;
  endproperty
  property p_idle;
    !start && !busy |=> !busy;
  endproperty
  property p_done;
    $fell(busy) |-> result_valid ^ error_flag;
  endproperty
  property p_excl;
    !(result_valid && error_flag);
  endproperty
  property p_busy;
    busy |-> !result_valid;
  endproperty
  property p_hold;
    !busy && !start |=> $stable(high_period) && $stable(low_period);
  endproperty
  property p_byte;
    1'b1 |=> byte_data ==
      sel($past(byte_addr), $past(high_period), $past(low_period));
  endproperty
  property p_upd;
    $changed(high_period) || $changed(low_period) |->
      busy || $rose(result_valid);
  endproperty
  a_take: assert property (p_take) else $error("start not taken");
  a_idle: assert property (p_idle) else $error("busy without start");
  a_done: assert property (p_done) else $error("end without flag");
  a_excl: assert property (p_excl) else $error("valid with error");
  a_busy: assert property (p_busy) else $error("valid while busy");
  a_hold: assert property (p_hold) else $error("result moved");
  a_byte: assert property (p_byte) else $error("byte mismatch");
  a_upd: assert property (p_upd) else $error("stray update");
endmodule

bind dctd_decoder dctd_sva i_dctd_sva (
  .ref_clk(ref_clk), .resetn(resetn), .sensor_in(sensor_in),
  .start(start), .byte_addr(byte_addr), .byte_data(byte_data),
  .high_period(high_period), .low_period(low_period), .busy(busy),
  .result_valid(result_valid), .error_flag(error_flag));

// >>> dctd_sensor_model.sv
/* Sensor model: a free square wave on one output line.
   Assumes the bench sets high and low times in ns. */
`timescale 1ns/100ps
module dctd_sensor_model (
  input  wire logic [31:0] hi_ns,
  input  wire logic [31:0] lo_ns,
  output logic             sensor_out
);
  // Own timing, unrelated in phase to the host clock.
  initial begin
    sensor_out = 1'b0;
    #7;
    forever begin
      sensor_out = 1'b1;
      #(hi_ns);
      sensor_out = 1'b0;
      #(lo_ns);
    end
  end
endmodule

// >>> dctd_decoder_tb.sv
/* Bench for the decoder with the sensor model.
   Assumes the package, checker and model compile first. */
`timescale 1ns/100ps
module dctd_decoder_tb;
  import dctd_pkg::*;
  logic        ref_clk, sensor_in, busy, result_valid, error_flag;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic [7:0]  byte_addr = 8'h00;
  logic [7:0]  byte_data, b0, b1, b2, b3;
  logic [15:0] high_period, low_period;
  int          hi_ns = 4800, lo_ns = 9600, err_count = 0, checks = 0, cyc = 0;
  // High ns, low ns, expected high and low ticks of 480 ns.
  int rows [4][4] = '{'{4800, 9600, 10, 20}, '{9600, 4800, 20, 10},
    '{12000, 28800, 25, 60}, '{2400, 2400, 5, 5}};
  dctd_decoder i_dctd_decoder (.ref_clk(ref_clk), .resetn(resetn),
    .sensor_in(sensor_in), .start(start), .byte_addr(byte_addr),
    .byte_data(byte_data), .high_period(high_period),
    .low_period(low_period), .busy(busy), .result_valid(result_valid),
    .error_flag(error_flag));
  dctd_sensor_model i_dctd_sensor_model (.hi_ns(hi_ns), .lo_ns(lo_ns),
    .sensor_out(sensor_in));
  //////////////////////////////////////////////////////////////////////////
  // Clock and hang limit.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // Compares within a tolerance of ticks.
  task automatic check(string n, logic [15:0] seen, int exp, int tol);
    bit ok;
    ok = 0;
    checks++;
    for (int e = exp - tol; e <= exp + tol; e++)
      if (seen === 16'(e)) ok = 1;
    if (!ok) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", n, exp, seen);
    end
  endtask
  task automatic do_reset();
    resetn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    check("busy rst", 16'(busy), 0, 0);
    check("high rst", high_period, 0, 0);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  // One measurement; dup sends a start that must be refused.
  task automatic measure(int hi, int lo, bit dup);
    int n;
    hi_ns = hi;
    lo_ns = lo;
    @(posedge ref_clk) start <= 1'b1;
    @(posedge ref_clk) start <= 1'b0;
    @(negedge ref_clk);
    check("busy", 16'(busy), 1, 0);
    check("valid clear", 16'(result_valid), 0, 0);
    if (dup) begin
      // Land the second start inside the high count of this run.
      @(posedge sensor_in);
      repeat (50) @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk) start <= 1'b0;
    end
    n = 0;
    while (busy !== 1'b0 && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    check("done", 16'(busy), 0, 0);
    // A taken restart would need a further full cycle of the line.
    if (dup) check("refused", 16'(n < 400), 1, 0);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] b);
    @(posedge ref_clk) byte_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk) b = byte_data;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Table rows back to back, then refusal and reset cases.
  initial begin
    do_reset();
    $display("reset test done");
    foreach (rows[i]) begin
      measure(rows[i][0], rows[i][1], 0);
      rd(8'h8A, b0);
      rd(8'h8C, b1);
      rd(8'h8B, b2);
      rd(8'h8D, b3);
      check("high", high_period, rows[i][2], 1);
      check("low", low_period, rows[i][3], 1);
      check("high bytes", {b1, b0}, rows[i][2], 1);
      check("low bytes", {b3, b2}, rows[i][3], 1);
      check("valid", 16'(result_valid), 1, 0);
      check("error", 16'(error_flag), 0, 0);
      $display("row %0d done", i);
    end
    rd(8'h00, b0);
    check("unmapped", {8'h00, b0}, 0, 0);
    $display("unmapped test done");
    measure(7200, 7200, 1);
    check("refused high", high_period, 15, 1);
    $display("refused start test done");
    @(posedge ref_clk) start <= 1'b1;
    @(posedge ref_clk) start <= 1'b0;
    repeat (100) @(posedge ref_clk);
    do_reset();
    measure(4800, 9600, 0);
    check("after reset", low_period, 20, 1);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
